// >>> pkg/ndv_pkg.sv
// shared constants and types for the normalizing non-restoring divider
package ndv_pkg;

  localparam int NDV_FRAC_W = 60;
  localparam int NDV_EXT_W = 7;
  localparam int NDV_EXP_W = 12;
  localparam int NDV_CNT_W = 7;
  localparam int NDV_ADDR_W = 12;

  // register byte offsets
  localparam logic [11:0] NDV_OFS_CTRL = 12'h000;
  localparam logic [11:0] NDV_OFS_STATUS = 12'h004;
  localparam logic [11:0] NDV_OFS_EXPDIFF = 12'h008;
  localparam logic [11:0] NDV_OFS_DIVD_LO = 12'h00c;
  localparam logic [11:0] NDV_OFS_DIVD_HI = 12'h010;
  localparam logic [11:0] NDV_OFS_DVSR_LO = 12'h014;
  localparam logic [11:0] NDV_OFS_DVSR_HI = 12'h018;
  localparam logic [11:0] NDV_OFS_QUO_LO = 12'h01c;
  localparam logic [11:0] NDV_OFS_QUO_HI = 12'h020;
  localparam logic [11:0] NDV_OFS_EXP = 12'h024;

  // field positions
  localparam int NDV_CTRL_START_BIT = 0;
  localparam int NDV_CTRL_DBL_BIT = 1;
  localparam int NDV_STAT_BUSY_BIT = 0;
  localparam int NDV_STAT_DONE_BIT = 1;
  localparam int NDV_HI_W = 28;

  // quotient layout in single precision
  localparam int NDV_SGL_EXT_HI = 30;
  localparam int NDV_SGL_EXT_LO = 24;
  localparam int NDV_QUOTIENT_NORM_SHIFTS_BIT = 58;

  // counts and constants
  localparam logic [NDV_EXP_W-1:0] NDV_QBITS_SGL = 12'h018;
  localparam logic [NDV_EXP_W-1:0] NDV_QBITS_DBL = 12'h038;
  localparam logic [NDV_EXP_W-1:0] NDV_EXP_ONE = 12'h001;
  localparam logic [NDV_EXP_W-1:0] NDV_EXP_BIAS = 12'h080;
  localparam logic [NDV_CNT_W-1:0] NDV_BYPASS_SHIFT = 7'h07;

  // extension patterns
  localparam logic [NDV_EXT_W-1:0] NDV_EXT_POS_IN = 7'h40;
  localparam logic [NDV_EXT_W-1:0] NDV_EXT_POS_OUT = 7'h00;
  localparam logic [NDV_EXT_W-1:0] NDV_EXT_NEG_IN = 7'h3f;
  localparam logic [NDV_EXT_W-1:0] NDV_EXT_NEG_OUT = 7'h7f;

  // reset values
  localparam logic [NDV_FRAC_W-1:0] NDV_FRAC_RST = 60'h000000000000000;
  localparam logic [NDV_EXP_W-1:0] NDV_EXP_RST = 12'h000;
  localparam logic [31:0] NDV_DATA_RST = 32'h00000000;

  typedef enum logic [1:0] {NDV_IDLE, NDV_RUN, NDV_DONE} ndv_state_t;

  // decisions made in one cycle and applied in the next
  typedef struct packed {
    logic [NDV_CNT_W-1:0] shift;
    logic sub;
    logic shift_in_range_flag;
    logic done;
  } ndv_step_t;

  localparam ndv_step_t NDV_STEP_FIRST = '{shift: 7'h00, sub: 1'b1, shift_in_range_flag: 1'b1, done: 1'b0};

endpackage : ndv_pkg

// >>> design/ndv_divider.sv
// fraction and exponent datapath of the normalizing non-restoring divider with apb registers
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module ndv_divider
  import ndv_pkg::*;
(
  input wire logic pclk, // apb clock, 25 MHz
  input wire logic presetn, // asynchronous reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high for write
  input wire logic [NDV_ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data, registered
  output logic pready, // apb ready, registered
  output logic pslverr // apb error for unmapped address, registered
);

  ////////////////////////////////////////////////////////////////////////////////
  // normalization counters

  // shifts until bits 59 and 58 differ
  function automatic logic [NDV_CNT_W-1:0] ndv_remainder_norm_shifts(input logic [NDV_FRAC_W-1:0] v);
    logic [NDV_CNT_W-1:0] n;
    logic stop;
    n = '0;
    stop = 1'b0;
    for (int i = NDV_FRAC_W - 2; i >= 0; i--)
    begin
      if (!stop && (v[i] == v[NDV_FRAC_W-1]))
        n = n + 7'h01;
      else
        stop = 1'b1;
    end
    return n;
  endfunction : ndv_remainder_norm_shifts

  // shifts until quotient bit 58 is one, counted through the extension
  function automatic logic [NDV_CNT_W-1:0] ndv_quotient_norm_shifts(input logic [NDV_FRAC_W+NDV_EXT_W-1:0] v);
    logic [NDV_CNT_W-1:0] n;
    logic stop;
    n = '0;
    stop = 1'b0;
    for (int i = NDV_QUOTIENT_NORM_SHIFTS_BIT + NDV_EXT_W; i >= 0; i--)
    begin
      if (!stop && !v[i])
        n = n + 7'h01;
      else
        stop = 1'b1;
    end
    return n;
  endfunction : ndv_quotient_norm_shifts

  ////////////////////////////////////////////////////////////////////////////////
  // state

  ndv_state_t state;
  ndv_step_t step;
  logic dbl;
  logic [NDV_EXP_W-1:0] expdiff;
  logic [NDV_FRAC_W-1:0] divd;
  logic [NDV_FRAC_W-1:0] divisor_selector;
  logic [NDV_FRAC_W-1:0] remainder_register;
  logic [NDV_FRAC_W-1:0] quotient_register;
  logic [NDV_EXT_W-1:0] quotient_extension_bits;
  logic [NDV_EXP_W-1:0] exponent_count;

  ////////////////////////////////////////////////////////////////////////////////
  // apb decode

  wire logic acc = psel && penable;
  wire logic wr_en = acc && pready && pwrite;
  wire logic hit_ctrl = (paddr == NDV_OFS_CTRL);
  wire logic hit_stat = (paddr == NDV_OFS_STATUS);
  wire logic hit_expd = (paddr == NDV_OFS_EXPDIFF);
  wire logic hit_dvl = (paddr == NDV_OFS_DIVD_LO);
  wire logic hit_dvh = (paddr == NDV_OFS_DIVD_HI);
  wire logic hit_dsl = (paddr == NDV_OFS_DVSR_LO);
  wire logic hit_dsh = (paddr == NDV_OFS_DVSR_HI);
  wire logic hit_qrl = (paddr == NDV_OFS_QUO_LO);
  wire logic hit_qrh = (paddr == NDV_OFS_QUO_HI);
  wire logic hit_exp = (paddr == NDV_OFS_EXP);
  wire logic mapped = hit_ctrl || hit_stat || hit_expd || hit_dvl || hit_dvh || hit_dsl || hit_dsh
                      || hit_qrl || hit_qrh || hit_exp;
  // a start bit written while busy restarts the divide from the held operands
  wire logic start = wr_en && hit_ctrl && pwdata[NDV_CTRL_START_BIT];

  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = NDV_DATA_RST;
    if (hit_ctrl)
      rd_mux[NDV_CTRL_DBL_BIT] = dbl;
    else if (hit_stat)
    begin
      rd_mux[NDV_STAT_BUSY_BIT] = (state == NDV_RUN);
      rd_mux[NDV_STAT_DONE_BIT] = (state == NDV_DONE);
    end
    else if (hit_expd)
      rd_mux[NDV_EXP_W-1:0] = expdiff;
    else if (hit_dvl)
      rd_mux = divd[31:0];
    else if (hit_dvh)
      rd_mux[NDV_HI_W-1:0] = divd[NDV_FRAC_W-1:32];
    else if (hit_dsl)
      rd_mux = divisor_selector[31:0];
    else if (hit_dsh)
      rd_mux[NDV_HI_W-1:0] = divisor_selector[NDV_FRAC_W-1:32];
    else if (hit_qrl)
      rd_mux = quotient_register[31:0];
    else if (hit_qrh)
      rd_mux[NDV_HI_W-1:0] = quotient_register[NDV_FRAC_W-1:32];
    else if (hit_exp)
      rd_mux[NDV_EXP_W-1:0] = exponent_count;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // divide step datapath

  // the range flag of the previous cycle picks the normal step or the bypass;
  // the last step after done always shifts by the quotient norm count, even when
  // the same cycle that raised done also cleared the range flag
  wire logic bypass = !step.shift_in_range_flag && !step.done;
  wire logic [NDV_CNT_W-1:0] shamt = bypass ? NDV_BYPASS_SHIFT : step.shift;
  wire logic [NDV_FRAC_W-1:0] ar_sh = remainder_register << shamt;
  // single precision keeps its extension inside the quotient, so nothing sits below bit 0
  wire logic [NDV_FRAC_W+NDV_EXT_W-1:0] q_cat = dbl ? {quotient_register, quotient_extension_bits}
                                                    : {quotient_register, NDV_EXT_POS_OUT};
  wire logic [NDV_FRAC_W+NDV_EXT_W-1:0] q_sh = q_cat << shamt;
  wire logic [NDV_FRAC_W-1:0] qr_sh = q_sh[NDV_FRAC_W+NDV_EXT_W-1:NDV_EXT_W];
  wire logic [NDV_FRAC_W-1:0] arith = step.sub ? ar_sh - divisor_selector
                                               : ar_sh + divisor_selector;
  wire logic [NDV_FRAC_W-1:0] ar_new = bypass ? ar_sh : arith;
  wire logic neg = ar_new[NDV_FRAC_W-1];

  logic [NDV_EXT_W-1:0] ext_new;
  always_comb
  begin
    if (bypass)
      ext_new = {NDV_EXT_W{ar_sh[NDV_FRAC_W-1]}};
    else if (!neg)
      ext_new = step.shift_in_range_flag ? NDV_EXT_POS_IN : NDV_EXT_POS_OUT;
    else
      ext_new = step.shift_in_range_flag ? NDV_EXT_NEG_IN : NDV_EXT_NEG_OUT;
  end

  wire logic [NDV_FRAC_W-1:0] qr_new = dbl ? qr_sh
                                           : {qr_sh[NDV_FRAC_W-1:NDV_SGL_EXT_HI+1], ext_new,
                                              qr_sh[NDV_SGL_EXT_LO-1:0]};
  wire logic [NDV_CNT_W-1:0] an = ndv_remainder_norm_shifts(ar_new);
  wire logic [NDV_CNT_W-1:0] qn = ndv_quotient_norm_shifts(dbl ? {qr_new, ext_new} : {qr_new, NDV_EXT_POS_OUT});
  wire logic done_new = (qn <= an);
  wire logic swr_new = !((an > NDV_BYPASS_SHIFT) && (qn > NDV_BYPASS_SHIFT));
  // a normal step never forms more than seven bits, so the remainder shift is clamped
  wire logic [NDV_CNT_W-1:0] an_cl = (an > NDV_BYPASS_SHIFT) ? NDV_BYPASS_SHIFT : an;
  wire ndv_step_t next_step = '{shift: done_new ? qn : an_cl, sub: !neg, shift_in_range_flag: swr_new,
                                done: done_new};

  ////////////////////////////////////////////////////////////////////////////////
  // exponent counter

  wire logic [NDV_EXP_W-1:0] exp_sh = exponent_count - NDV_EXP_W'(shamt);
  // a start write may set the precision in the same transfer, so the count loaded
  // at start follows the written bit, not the register it is about to replace
  wire logic dbl_now = start ? pwdata[NDV_CTRL_DBL_BIT] : dbl;
  wire logic [NDV_EXP_W-1:0] qbits = dbl_now ? NDV_QBITS_DBL : NDV_QBITS_SGL;
  wire logic [NDV_EXP_W-1:0] exp_start = expdiff + qbits + NDV_EXP_ONE;
  // the bias goes in with the last shift, so the exponent never shows it half done
  wire logic [NDV_EXP_W-1:0] exp_final = exp_sh + NDV_EXP_BIAS;

  ////////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, data and error registered with ready

  wire logic first_acc = acc && !pready;
  wire logic [31:0] next_prdata = (first_acc && !pwrite) ? rd_mux : NDV_DATA_RST;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= NDV_DATA_RST;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= first_acc;
      prdata <= next_prdata;
      pslverr <= first_acc && !mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dbl <= 1'b0;
      expdiff <= NDV_EXP_RST;
      divd <= NDV_FRAC_RST;
      divisor_selector <= NDV_FRAC_RST;
    end
    else if (wr_en)
    begin
      if (hit_ctrl)
        dbl <= pwdata[NDV_CTRL_DBL_BIT];
      if (hit_expd)
        expdiff <= pwdata[NDV_EXP_W-1:0];
      if (hit_dvl)
        divd[31:0] <= pwdata;
      if (hit_dvh)
        divd[NDV_FRAC_W-1:32] <= pwdata[NDV_HI_W-1:0];
      if (hit_dsl)
        divisor_selector[31:0] <= pwdata;
      if (hit_dsh)
        divisor_selector[NDV_FRAC_W-1:32] <= pwdata[NDV_HI_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // divide sequencer

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= NDV_IDLE;
      step <= NDV_STEP_FIRST;
      remainder_register <= NDV_FRAC_RST;
      quotient_register <= NDV_FRAC_RST;
      quotient_extension_bits <= NDV_EXT_POS_OUT;
      exponent_count <= NDV_EXP_RST;
    end
    else if (start)
    begin
      state <= NDV_RUN;
      step <= NDV_STEP_FIRST;
      remainder_register <= divd;
      quotient_register <= NDV_FRAC_RST;
      quotient_extension_bits <= NDV_EXT_POS_OUT;
      exponent_count <= exp_start;
    end
    else
    begin
      case (state)
        NDV_RUN:
        begin
          if (step.done)
          begin
            // final shift normalizes the quotient; the arithmetic result is dropped
            state <= NDV_DONE;
            remainder_register <= ar_sh;
            quotient_register <= qr_sh;
            exponent_count <= exp_final;
          end
          else
          begin
            step <= next_step;
            remainder_register <= ar_new;
            quotient_register <= qr_new;
            // in double precision the extension flops keep the bits not yet shifted into the quotient
            quotient_extension_bits <= ext_new;
            exponent_count <= exp_sh;
          end
        end
        NDV_IDLE:
          state <= NDV_IDLE;
        NDV_DONE:
          // quotient, exponent and remainder hold until the next start
          state <= NDV_DONE;
        default:
          // an unused state code falls back to idle rather than locking up
          state <= NDV_IDLE;
      endcase
    end
  end

endmodule : ndv_divider

`default_nettype wire

// >>> verif/ndv_divider_properties.sv
// apb port checker for the divider register block
`timescale 1ns/1ns
`default_nettype none
module ndv_divider_properties
  import ndv_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // select
  input wire logic penable, // access phase
  input wire logic pwrite, // direction
  input wire logic [NDV_ADDR_W-1:0] paddr, // address
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr // error
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire mapped = (paddr[1:0] == 2'h0) && (paddr <= NDV_OFS_EXP);
  wire rd_ack = pready && !pwrite;

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    s_setup ##1 (psel && penable);
  endsequence

  property p_one_wait;
    s_access |=> pready;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("ready not one cycle after access");
  property p_pulse;
    $rose(pready) |=> $fell(pready);
  endproperty
  a_pulse: assert property (p_pulse) else $error("ready held too long");
  property p_in_access;
    pready |-> psel && penable;
  endproperty
  a_in_access: assert property (p_in_access) else $error("ready outside access");
  property p_err_cause;
    pready |-> (pslverr == !mapped);
  endproperty
  a_err_cause: assert property (p_err_cause) else $error("error flag does not match map");
  property p_err_alone;
    pslverr |-> pready;
  endproperty
  a_err_alone: assert property (p_err_alone) else $error("error without ready");
  property p_rdata_quiet;
    !rd_ack |-> prdata == 32'h00000000;
  endproperty
  a_rdata_quiet: assert property (p_rdata_quiet) else $error("read data outside read answer");
  property p_start_pulse;
    rd_ack && paddr == NDV_OFS_CTRL |-> prdata[31:2] == 30'h0 && !prdata[0];
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start bit reads back");
  property p_busy_done;
    rd_ack && paddr == NDV_OFS_STATUS |-> !(prdata[0] && prdata[1]) && prdata[31:2] == 30'h0;
  endproperty
  a_busy_done: assert property (p_busy_done) else $error("busy and done together");
endmodule : ndv_divider_properties
bind ndv_divider ndv_divider_properties u_ndv_divider_properties(.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr));
`default_nettype wire

// >>> verif/ndv_seq_model.sv
// sequencer model: issues apb transfers toward the divider
`timescale 1ns/1ns
`default_nettype none
module ndv_seq_model
  import ndv_pkg::*;
(
  input wire logic pclk, // clock
  output logic psel, // select
  output logic penable, // access phase
  output logic pwrite, // direction
  output logic [NDV_ADDR_W-1:0] paddr, // address
  output logic [31:0] pwdata, // write data
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr // error
);
  logic hung;
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    hung = 1'b0;
  end
  // request held until pready is sampled; released bus shows inverted values, not stale ones
  task xfer(input logic w, input logic [NDV_ADDR_W-1:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (!pready && n < 50);
    rd = prdata;
    err = pslverr;
    hung = !pready;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : ndv_seq_model
`default_nettype wire

// >>> verif/testbench.sv
// self-checking bench: register access and full divide runs
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import ndv_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [NDV_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] diffs [2] = '{12'h010, 12'hff0};
  int num_errors, checked, n;

  ndv_divider u_ndv_divider(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  ndv_seq_model u_ndv_seq_model(.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want)
    begin
      num_errors++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  task end_of_test;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    u_ndv_seq_model.xfer(w, a, d, rd, err);
    if (u_ndv_seq_model.hung)
    begin
      num_errors++;
      $display("BAD %0t no ready", $time);
      end_of_test();
    end
  endtask : bus
  // addresses above the last register must answer with an error
  task rchk(input logic [11:0] a, input logic [31:0] want);
    bus(1'b0, a, 32'h00000000);
    check(rd, want);
    check({31'h0, err}, {31'h0, a > NDV_OFS_EXP});
  endtask : rchk
  // divisor is one half; precision written first, then start, poll, results
  task divide(input logic d, input logic [31:0] dvd_hi, input logic [31:0] dvd_lo, input logic [11:0] diff,
    input logic [31:0] q_hi, input logic [31:0] q_lo, input logic [11:0] shifts);
    bus(1'b1, NDV_OFS_DIVD_LO, dvd_lo);
    bus(1'b1, NDV_OFS_DIVD_HI, dvd_hi);
    bus(1'b1, NDV_OFS_DVSR_LO, 32'h00000000);
    bus(1'b1, NDV_OFS_DVSR_HI, 32'h04000000);
    bus(1'b1, NDV_OFS_EXPDIFF, {20'h0, diff});
    bus(1'b1, NDV_OFS_CTRL, {30'h0, d, 1'b0});
    bus(1'b1, NDV_OFS_CTRL, {30'h0, d, 1'b1});
    rchk(NDV_OFS_STATUS, 32'h00000001);
    n = 0;
    do
    begin
      bus(1'b0, NDV_OFS_STATUS, 32'h00000000);
      n++;
    end
    while (rd[1] !== 1'b1 && n < 60);
    if (rd[1] !== 1'b1)
    begin
      num_errors++;
      $display("BAD %0t divide never done", $time);
      end_of_test();
    end
    rchk(NDV_OFS_STATUS, 32'h00000002);
    rchk(NDV_OFS_QUO_LO, q_lo);
    rchk(NDV_OFS_QUO_HI, q_hi);
    // loaded bit count plus one, less every place shifted, plus the bias
    rchk(NDV_OFS_EXP, {20'h0, diff + (d ? NDV_QBITS_DBL : NDV_QBITS_SGL) + NDV_EXP_ONE - shifts + NDV_EXP_BIAS});
    repeat (10) @(posedge pclk);
    rchk(NDV_OFS_QUO_HI, q_hi);
  endtask : divide
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    presetn = 1'b0;
    num_errors = 0;
    checked = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rchk(NDV_OFS_STATUS, 32'h00000000);
    rchk(NDV_OFS_QUO_LO, 32'h00000000);
    rchk(NDV_OFS_EXP, 32'h00000000);
    rchk(12'h028, 32'h00000000);
    $display("test reset done");
    // dividend just under one, divisor one half; start bit masked off, so no divide runs and the quotient reads zero
    bus(1'b1, NDV_OFS_DIVD_LO, 32'hffffffff);
    bus(1'b1, NDV_OFS_DIVD_HI, 32'h07ffffff);
    bus(1'b1, NDV_OFS_DVSR_LO, 32'h00000000);
    bus(1'b1, NDV_OFS_DVSR_HI, 32'h04000000);
    bus(1'b1, NDV_OFS_CTRL, 32'h00000003 & 32'h00000002);
    rchk(NDV_OFS_CTRL, 32'h00000002);
    bus(1'b1, NDV_OFS_CTRL, 32'h00000000);
    bus(1'b1, NDV_OFS_QUO_LO, 32'h00001234);
    rchk(NDV_OFS_QUO_LO, 32'h00000000);
    $display("test registers done");
    // dividend just under one, divisor one half: one bit per step, 28 places shifted
    foreach (diffs[i])
    begin
      divide(1'b0, 32'h07ffffff, 32'hffffffff, diffs[i], 32'h07ffffff, 32'h80000000, 12'h01c);
      $display("test divide %0d done", i);
    end
    // dividend one part in 2^18 above the divisor: both norms out of range, two bypass steps,
    // then done raised in the same cycle that clears the range flag
    divide(1'b0, 32'h04000100, 32'h00000000, 12'h010, 32'h04000100, 32'h00000000, 12'h01c);
    $display("test bypass single done");
    divide(1'b1, 32'h04000100, 32'h00000000, 12'h010, 32'h04000100, 32'h00000000, 12'h03b);
    $display("test bypass double done");
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
